// ==== src/aisw_setup_words.sv ====
// Setup word registers of the eight-input analog input unit and their per-input decode.
//
// Contract
// [R1] One bit of word 0 selects binary (0) or BCD (1) output for all inputs.
// [R2] Word 0 low byte inhibits conversion per input: 0 converts, 1 stops.
// [R3] Inhibit bit 0 is input 1, rising to bit 7 for input 8.
// [R4] Word 1 holds two range bits per input, bits 15:14 input 8, 1:0 input 1.
// [R5] The first-named bit of each range pair is the more significant bit.
// [R6] Word 2 upper byte enables scaling per input when the bit is one.
// [R7] Scaling byte lowest bit is input 1, highest bit input 8.
// [R8] Word 2 lower byte enables mean-value processing per input when one.
// [R9] Word 3 upper byte enables square-root processing per input when one.
// [R10] Controller writes all setup words before conversion starts; settings then persist.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
module aisw_setup_words
    import aisw_pkg::*;
#(
    parameter int N_INPUTS = aisw_pkg::AISW_INPUTS
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic [aisw_pkg::AISW_ADDR_W-1:0] addr,
    input  wire logic [aisw_pkg::AISW_DATA_W-1:0] wdata,
    input  wire logic                           wr_stb,
    input  wire logic                           rd_stb,
    output logic      [aisw_pkg::AISW_DATA_W-1:0] rdata,
    output logic                                fmt_bcd,
    output logic      [N_INPUTS-1:0]            conv_enable,
    output logic      [2*N_INPUTS-1:0]          range_sel,
    output logic      [N_INPUTS-1:0]            scale_en,
    output logic      [N_INPUTS-1:0]            avg_en,
    output logic      [N_INPUTS-1:0]            sqrt_en,
    output logic                                configured
);
    import aisw_pkg::*;

    logic [15:0] conv_ctrl_reg;
    logic [15:0] conv_ctrl_next;
    logic [15:0] range_reg;
    logic [15:0] range_next;
    logic [15:0] scale_avg_reg;
    logic [15:0] scale_avg_next;
    logic [15:0] sqrt_reg;
    logic [15:0] sqrt_next;
    logic [3:0]  written_reg;
    logic [3:0]  written_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    // Word select used by both the write and the read decode.
    function automatic logic is_word(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction

    always_comb begin
        conv_ctrl_next = conv_ctrl_reg;
        range_next     = range_reg;
        scale_avg_next = scale_avg_reg;
        sqrt_next      = sqrt_reg;
        written_next   = written_reg;
        if (wr_stb) begin
            // Bits 15:10 of word 0 and the limit warning byte of word 3 are not stored.
            if (is_word(addr, AISW_OFS_CONV_CTRL)) begin
                conv_ctrl_next  = wdata & AISW_CONV_CTRL_MASK;
                written_next[0] = 1'b1;
            end
            if (is_word(addr, AISW_OFS_RANGE)) begin
                range_next      = wdata;
                written_next[1] = 1'b1;
            end
            if (is_word(addr, AISW_OFS_SCALE_AVG)) begin
                scale_avg_next  = wdata;
                written_next[2] = 1'b1;
            end
            if (is_word(addr, AISW_OFS_SQRT)) begin
                sqrt_next       = wdata & AISW_SQRT_MASK;
                written_next[3] = 1'b1;
            end
        end
    end

    always_comb begin
        rdata_next = 16'h0000;
        if (rd_stb) begin
            if (is_word(addr, AISW_OFS_CONV_CTRL)) begin
                rdata_next = conv_ctrl_reg;
            end else if (is_word(addr, AISW_OFS_RANGE)) begin
                rdata_next = range_reg;
            end else if (is_word(addr, AISW_OFS_SCALE_AVG)) begin
                rdata_next = scale_avg_reg;
            end else if (is_word(addr, AISW_OFS_SQRT)) begin
                rdata_next = sqrt_reg;
            end else if (is_word(addr, AISW_OFS_STATUS)) begin
                rdata_next = {12'h000, written_reg};
            end else begin
                rdata_next = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_ctrl_reg <= AISW_CONV_CTRL_RST;
            range_reg     <= AISW_RANGE_RST;
            scale_avg_reg <= AISW_SCALE_AVG_RST;
            sqrt_reg      <= AISW_SQRT_RST;
            written_reg   <= 4'h0;
            rdata_reg     <= 16'h0000;
        end else begin
            conv_ctrl_reg <= conv_ctrl_next;
            range_reg     <= range_next;
            scale_avg_reg <= scale_avg_next;
            sqrt_reg      <= sqrt_next;
            written_reg   <= written_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign rdata      = rdata_reg;
    assign fmt_bcd    = conv_ctrl_reg[AISW_FMT_BIT];   // [R1]
    // Informative only: the enables are not gated by it, so the controller must
    // load every word before it relies on the conversions.
    assign configured = &written_reg;                  // [R10]

    genvar gi;
    generate
        for (gi = 0; gi < N_INPUTS; gi++) begin : g_in
            assign conv_enable[gi] = ~conv_ctrl_reg[AISW_INHIBIT_LSB + gi];  // [R2] [R3]
            assign range_sel[2*gi+1] = range_reg[2*gi+1];                    // [R4] [R5]
            assign range_sel[2*gi]   = range_reg[2*gi];                      // [R4]
            assign scale_en[gi] = scale_avg_reg[AISW_SCALE_LSB + gi];        // [R6] [R7]
            assign avg_en[gi]   = scale_avg_reg[AISW_AVG_LSB + gi];          // [R8]
            assign sqrt_en[gi]  = sqrt_reg[AISW_SQRT_LSB + gi];              // [R9]
        end
    endgenerate

    property p_fmt_follows_write;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_CONV_CTRL) |=> (fmt_bcd == $past(wdata[AISW_FMT_BIT]));
    endproperty
    a_fmt_follows_write: assert property (p_fmt_follows_write) else $error("format bit wrong"); // [R1]

    property p_inhibit;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_CONV_CTRL) |=> (conv_enable == ~$past(wdata[7:0]));
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("conversion enable wrong"); // [R2]

    property p_input1_lsb;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_CONV_CTRL && wdata[7:0] == 8'h01) |=>
            (conv_enable[0] == 1'b0 && conv_enable[7] == 1'b1);
    endproperty
    a_input1_lsb: assert property (p_input1_lsb) else $error("input 1 not on bit 0"); // [R3]

    property p_range;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_RANGE) |=>
            (range_sel[15:14] == $past(wdata[15:14]) && range_sel[1:0] == $past(wdata[1:0]));
    endproperty
    a_range: assert property (p_range) else $error("range mapping wrong"); // [R4]

    property p_range_msb;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_RANGE && wdata[1:0] == 2'h2) |=> range_sel[1];
    endproperty
    a_range_msb: assert property (p_range_msb) else $error("range pair order wrong"); // [R5]

    property p_scale;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_SCALE_AVG) |=>
            (scale_en == $past(wdata[15:8]) && scale_en[0] == $past(wdata[8]));
    endproperty
    a_scale: assert property (p_scale) else $error("scaling enable wrong"); // [R6] [R7]

    property p_avg;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_SCALE_AVG) |=> (avg_en == $past(wdata[7:0]));
    endproperty
    a_avg: assert property (p_avg) else $error("averaging enable wrong"); // [R8]

    property p_sqrt_hold;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_SQRT) ##1 (!(wr_stb && addr == AISW_OFS_SQRT)) [*3]
            |-> (sqrt_en == $past(wdata[15:8], 3));
    endproperty
    a_sqrt_hold: assert property (p_sqrt_hold) else $error("sqrt enable lost"); // [R9] [R10]

    // Both ends of each per-input field are pinned down, not only the lowest input.
    property p_input8_msb;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_CONV_CTRL && wdata[7:0] == 8'h80) |=>
            (conv_enable[N_INPUTS-1] == 1'b0 && conv_enable[0] == 1'b1);
    endproperty
    a_input8_msb: assert property (p_input8_msb) else $error("input 8 not on bit 7"); // [R3]

    property p_range_mid;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_RANGE) |=> (range_sel[7:6] == $past(wdata[7:6]));
    endproperty
    a_range_mid: assert property (p_range_mid) else $error("input 4 range wrong"); // [R4]

    property p_top_enables;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr == AISW_OFS_SCALE_AVG) |=>
            (scale_en[N_INPUTS-1] == $past(wdata[15]) && avg_en[N_INPUTS-1] == $past(wdata[7]));
    endproperty
    a_top_enables: assert property (p_top_enables) else $error("top enable wrong"); // [R7] [R8]

    // Checked without a disable so that the reset values themselves are pinned down.
    property p_reset_values;
        @(posedge clk)
        rst |=> (fmt_bcd == 1'b0 && conv_enable == '1 && range_sel == '0 && configured == 1'b0
                 && scale_en == '0 && avg_en == '0 && sqrt_en == '0 && rdata == '0);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // [R2]

    // Between writes of its own word every decoded output must stand still.
    property p_word0_hold;
        @(posedge clk) disable iff (rst)
        !(wr_stb && addr == AISW_OFS_CONV_CTRL) |=> ($stable(fmt_bcd) && $stable(conv_enable));
    endproperty
    a_word0_hold: assert property (p_word0_hold) else $error("word 0 moved"); // [R1] [R2]

    property p_word1_hold;
        @(posedge clk) disable iff (rst)
        !(wr_stb && addr == AISW_OFS_RANGE) |=> $stable(range_sel);
    endproperty
    a_word1_hold: assert property (p_word1_hold) else $error("word 1 moved"); // [R4]

    property p_word2_hold;
        @(posedge clk) disable iff (rst)
        !(wr_stb && addr == AISW_OFS_SCALE_AVG) |=> ($stable(scale_en) && $stable(avg_en));
    endproperty
    a_word2_hold: assert property (p_word2_hold) else $error("word 2 moved"); // [R6] [R8]

    property p_word3_hold;
        @(posedge clk) disable iff (rst)
        !(wr_stb && addr == AISW_OFS_SQRT) |=> $stable(sqrt_en);
    endproperty
    a_word3_hold: assert property (p_word3_hold) else $error("word 3 moved"); // [R9]

    // A write to an unmapped index must leave range_sel, conv_enable and sqrt_en alone.
    property p_unmapped_write;
        @(posedge clk) disable iff (rst)
        (wr_stb && addr > AISW_OFS_STATUS) |=>
            ($stable(range_sel) && $stable(conv_enable) && $stable(sqrt_en));
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");

    property p_cfg_sticky;
        @(posedge clk) disable iff (rst)
        configured |=> configured;
    endproperty
    a_cfg_sticky: assert property (p_cfg_sticky) else $error("configured dropped"); // [R10]

    property p_cfg_rise;
        @(posedge clk) disable iff (rst)
        $rose(configured) |-> $past(wr_stb);
    endproperty
    a_cfg_rise: assert property (p_cfg_rise) else $error("configured rose alone"); // [R10]

    // Read data stand in the cycle after the strobe only and are zero otherwise.
    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
        !rd_stb |=> (rdata == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

    property p_rd_conv;
        @(posedge clk) disable iff (rst)
        (rd_stb && addr == AISW_OFS_CONV_CTRL) |=>
            (rdata[AISW_FMT_BIT] == $past(fmt_bcd) && rdata[7:0] == ~$past(conv_enable)
             && rdata[15:10] == 6'h00);
    endproperty
    a_rd_conv: assert property (p_rd_conv) else $error("word 0 readback"); // [R1] [R2]

    property p_rd_range;
        @(posedge clk) disable iff (rst)
        (rd_stb && addr == AISW_OFS_RANGE) |=>
            (rdata == $past(range_sel));
    endproperty
    a_rd_range: assert property (p_rd_range) else $error("word 1 readback"); // [R4]

    property p_rd_scale_avg;
        @(posedge clk) disable iff (rst)
        (rd_stb && addr == AISW_OFS_SCALE_AVG) |=>
            (rdata == {$past(scale_en), $past(avg_en)});
    endproperty
    a_rd_scale_avg: assert property (p_rd_scale_avg) else $error("word 2 readback"); // [R6] [R8]

    property p_rd_sqrt;
        @(posedge clk) disable iff (rst)
        (rd_stb && addr == AISW_OFS_SQRT) |=> (rdata == {$past(sqrt_en), 8'h00});
    endproperty
    a_rd_sqrt: assert property (p_rd_sqrt) else $error("word 3 readback"); // [R9]

    property p_rd_status;
        @(posedge clk) disable iff (rst)
        (rd_stb && addr == AISW_OFS_STATUS) |=>
            (rdata[15:4] == 12'h000 && (&rdata[3:0]) == $past(configured));
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status readback"); // [R10]

    // Covers show that the bench reaches the main configurations.
    c_bcd: cover property (@(posedge clk) disable iff (rst) $rose(fmt_bcd));
    c_configured: cover property (@(posedge clk) disable iff (rst) $rose(configured));
    c_all_off: cover property (@(posedge clk) disable iff (rst) conv_enable == 8'h00);
    c_status_full: cover property (@(posedge clk) disable iff (rst)
        (rd_stb && addr == AISW_OFS_STATUS) ##1 (rdata == 16'h000F));
    c_input8_off: cover property (@(posedge clk) disable iff (rst) conv_enable == 8'h7F);
endmodule // aisw_setup_words

// ==== src/aisw_pkg.sv ====
// Package with register offsets, field positions and reset values of the setup word block.
package aisw_pkg;
    localparam int          AISW_INPUTS          = 8;
    localparam int          AISW_ADDR_W          = 4;
    localparam int          AISW_DATA_W          = 16;
    localparam logic [3:0]  AISW_OFS_CONV_CTRL   = 4'h0;
    localparam logic [3:0]  AISW_OFS_RANGE       = 4'h1;
    localparam logic [3:0]  AISW_OFS_SCALE_AVG   = 4'h2;
    localparam logic [3:0]  AISW_OFS_SQRT        = 4'h3;
    localparam logic [3:0]  AISW_OFS_STATUS      = 4'h4;
    localparam int          AISW_FMT_BIT         = 8;
    localparam int          AISW_INHIBIT_LSB     = 0;
    localparam int          AISW_SCALE_LSB       = 8;
    localparam int          AISW_AVG_LSB         = 0;
    localparam int          AISW_SQRT_LSB        = 8;
    localparam logic [15:0] AISW_CONV_CTRL_RST   = 16'h0000;
    localparam logic [15:0] AISW_RANGE_RST       = 16'h0000;
    localparam logic [15:0] AISW_SCALE_AVG_RST   = 16'h0000;
    localparam logic [15:0] AISW_SQRT_RST        = 16'h0000;
    localparam logic [15:0] AISW_CONV_CTRL_MASK  = 16'h03FF;
    localparam logic [15:0] AISW_SQRT_MASK       = 16'hFF00;
endpackage

// ==== tb/aisw_cpu_model.sv ====
// Controller model that writes and reads the setup words over the register bus.
`timescale 1ns/1ns
module aisw_cpu_model (
    input  wire logic        clk,
    output logic      [3:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr_stb,
    output logic             rd_stb,
    input  wire logic [15:0] rdata
);
    initial begin
        addr = 4'h0;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    // One word per call; the bench checks the word 0 enables before words 1 to 3 are written.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        wdata  <= ~d;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule // aisw_cpu_model

// ==== tb/testbench.sv ====
// Self-checking testbench for the setup word block.
`timescale 1ns/1ns
module testbench;
    import aisw_pkg::*;
    logic        clk, rst, fmt_bcd, wr_stb, rd_stb, configured;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, range_sel, v;
    logic [7:0]  conv_enable, scale_en, avg_en, sqrt_en;
    int          errors, samples_checked;

    aisw_cpu_model cpu_u (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata));
    aisw_setup_words dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .fmt_bcd(fmt_bcd),
        .conv_enable(conv_enable), .range_sel(range_sel), .scale_en(scale_en),
        .avg_en(avg_en), .sqrt_en(sqrt_en), .configured(configured));

    always #4 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_reset();
        chk("conv_enable", 16'h00FF, {8'h00, conv_enable});
        chk("fmt_bcd", 16'h0000, {15'h0000, fmt_bcd});
        chk("configured", 16'h0000, {15'h0000, configured});
        for (int a = 0; a < 6; a++) begin
            cpu_u.rd(a[3:0], v);
            chk("reset word", 16'h0000, v);
        end
        $display("test reset done");
    endtask
    task automatic t_conv();
        cpu_u.wr(AISW_OFS_CONV_CTRL, 16'h0100);
        chk("fmt_bcd", 16'h0001, {15'h0000, fmt_bcd});
        chk("conv_enable", 16'h00FF, {8'h00, conv_enable});
        for (int i = 0; i < 8; i++) begin
            cpu_u.wr(AISW_OFS_CONV_CTRL, 16'h0001 << i);
            chk("conv_enable", {8'h00, ~(8'h01 << i)}, {8'h00, conv_enable});
            chk("fmt_bcd", 16'h0000, {15'h0000, fmt_bcd});
        end
        cpu_u.wr(AISW_OFS_CONV_CTRL, 16'hFFFF);
        chk("conv_enable", 16'h0000, {8'h00, conv_enable});
        cpu_u.rd(AISW_OFS_CONV_CTRL, v);
        chk("word0 read", 16'h03FF, v);
        $display("test conversion control done");
    endtask
    task automatic t_words();
        cpu_u.wr(AISW_OFS_RANGE, 16'h8001);
        chk("range input8", 16'h0002, {14'h0000, range_sel[15:14]});
        chk("range input1", 16'h0001, {14'h0000, range_sel[1:0]});
        cpu_u.wr(AISW_OFS_RANGE, 16'h4C02);
        chk("range_sel", 16'h4C02, range_sel);
        cpu_u.wr(AISW_OFS_SCALE_AVG, 16'h8001);
        chk("scale_en", 16'h0080, {8'h00, scale_en});
        chk("avg_en", 16'h0001, {8'h00, avg_en});
        cpu_u.wr(AISW_OFS_SCALE_AVG, 16'h0180);
        chk("scale_en", 16'h0001, {8'h00, scale_en});
        chk("avg_en", 16'h0080, {8'h00, avg_en});
        cpu_u.wr(AISW_OFS_SQRT, 16'h01FF);
        chk("sqrt_en", 16'h0001, {8'h00, sqrt_en});
        cpu_u.rd(AISW_OFS_SQRT, v);
        chk("word3 read", 16'h0100, v);
        cpu_u.wr(4'h9, 16'hFFFF);
        cpu_u.rd(4'h9, v);
        chk("unmapped read", 16'h0000, v);
        chk("range kept", 16'h4C02, range_sel);
        chk("sqrt kept", 16'h0001, {8'h00, sqrt_en});
        chk("configured", 16'h0001, {15'h0000, configured});
        cpu_u.rd(AISW_OFS_STATUS, v);
        chk("status word", 16'h000F, v);
        $display("test setup words done");
    endtask
    // A reset in mid-run must clear words 0, 1 and 3 and the status and allow a request right after release.
    task automatic t_mid_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("configured", 16'h0000, {15'h0000, configured});
        chk("conv_enable", 16'h00FF, {8'h00, conv_enable});
        chk("range_sel", 16'h0000, range_sel);
        chk("sqrt_en", 16'h0000, {8'h00, sqrt_en});
        cpu_u.wr(AISW_OFS_CONV_CTRL, 16'h0101);
        chk("fmt_bcd", 16'h0001, {15'h0000, fmt_bcd});
        chk("conv_enable", 16'h00FE, {8'h00, conv_enable});
        cpu_u.rd(AISW_OFS_CONV_CTRL, v);
        chk("word0 read", 16'h0101, v);
        @(posedge clk);
        #1;
        chk("rdata after read", 16'h0000, rdata);
        $display("test mid-run reset done");
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_conv();
        t_words();
        t_mid_reset();
        wrap_up();
    end
    // A hang counts as a mismatch and ends the run through the normal report.
    initial begin
        #100000;
        errors++;
        wrap_up();
    end
endmodule // testbench
